// ### logic/phtp_trigger.v
`timescale 1ns/1ps
`include "phtp_map.vh"
module phtp_trigger (
   input wire clk_sys,
   input wire sys_rst,
   input wire regWrite,
   input wire regRead,
   input wire [7:0] regAddr,
   input wire [15:0] regWdata,
   output reg [15:0] regRdata,
   input wire [15:0] dischargeCurrentMa,
   input wire comparatorTrip,
   input wire criticalInputCurrent,
   input wire nominalInputCurrent,
   input wire lowSystemVoltage,
   input wire batteryPresentSignal,
   input wire adapterPresent,
   output reg processorHotAlert_n
);
   ////////////////////////////////////////////////////////////////////////
   // Registers and pin synchronisers
   // Option zero holds the pulse control bits, option two the profile
   reg [15:0] optTwo_r;
   reg [15:0] optZero_r;
   reg [4:0] pinS1_r;
   reg [4:0] pinS2_r;
   reg battPrev_r;
   reg adptPrev_r;
   reg [15:0] currS1_r;
   reg [15:0] currS2_r;
   reg [15:0] currS3_r;
   reg [15:0] currHeld_r;
   reg [23:0] pulseCnt_r;
   reg alertActive_r;
   reg pending_r;

   wire [5:0] vthCode = optTwo_r[`PHTP_VTH_HI:`PHTP_VTH_LO];
   wire [1:0] degSel = optTwo_r[`PHTP_DEG_HI:`PHTP_DEG_LO];
   wire [1:0] widSel = optZero_r[`PHTP_WID_HI:`PHTP_WID_LO];
   wire extEnable = optZero_r[`PHTP_EXT_BIT];
   wire functionOn = |optTwo_r[6:0];

   // Threshold in mA: code*512 + 128
   // Top code gives 32256 mA plus the offset, still well inside 16 bits
   wire [15:0] thresholdMa = {vthCode, 9'h000} + 16'h0080;
   // Strictly greater, so a current sitting right on the threshold stays quiet
   wire dischargeOver = currHeld_r > thresholdMa;

   // Deglitch time lookup; counts assume the 40 MHz clock, so a faster clock
   // shortens every time in proportion
   reg [23:0] degCycles;
   always @* begin
      case (degSel)
         2'b00: degCycles = `PHTP_C1600US;
         2'b01: degCycles = `PHTP_C100US;
         2'b10: degCycles = `PHTP_C6MS;
         default: degCycles = `PHTP_C12MS;
      endcase
   end

   // Minimum pulse width lookup; note code 11 is the 5 ms setting
   reg [23:0] widCycles;
   always @* begin
      case (widSel)
         2'b00: widCycles = `PHTP_C100US;
         2'b01: widCycles = `PHTP_C1MS;
         2'b10: widCycles = `PHTP_C10MS;
         default: widCycles = `PHTP_C5MS;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Register access; clear bit returns to idle 1 after use
   // A host write wins over that restore; the release itself is taken from
   // the write strobe, so a clear is never lost to the restore
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         optTwo_r <= `PHTP_OPT_TWO_RST;
         optZero_r <= `PHTP_OPT_ZERO_RST;
      end else if (regWrite && regAddr == `PHTP_OPT_TWO_ADDR) begin
         optTwo_r <= regWdata;
      end else if (regWrite && regAddr == `PHTP_OPT_ZERO_ADDR) begin
         optZero_r <= regWdata;
      end else if (!optZero_r[`PHTP_CLR_BIT] && !alertActive_r) begin
         optZero_r[`PHTP_CLR_BIT] <= 1'b1;
      end
   end

   // Read mux, registered; unmapped reads zero
   // Data stands until the next read strobe
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         regRdata <= 16'h0000;
      end else if (regRead) begin
         case (regAddr)
            `PHTP_OPT_TWO_ADDR: regRdata <= optTwo_r;
            `PHTP_OPT_ZERO_ADDR: regRdata <= optZero_r;
            default: regRdata <= 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Two-stage sync of asynchronous levels and the current word
   // Pin levels pass two flops before any logic looks at them
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         pinS1_r <= 5'h00;
         pinS2_r <= 5'h00;
         currS1_r <= 16'h0000;
         currS2_r <= 16'h0000;
      end else begin
         pinS1_r <= {adapterPresent, batteryPresentSignal, comparatorTrip,
                     criticalInputCurrent, nominalInputCurrent};
         pinS2_r <= pinS1_r;
         currS1_r <= dischargeCurrentMa; // Qualified further below
         currS2_r <= currS1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Current word capture: the word crosses domains as sixteen loose bits,
   // so it is taken only once two successive synced samples agree; two
   // cycles of latency are nothing next to the deglitch time
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         currS3_r <= 16'h0000;
         currHeld_r <= 16'h0000;
      end else begin
         currS3_r <= currS2_r;
         if (currS2_r == currS3_r) begin
            currHeld_r <= currS2_r;
         end
      end
   end

   // Deglitched sources; comparator, critical and nominal are pre-filtered
   wire dchgQual;
   wire vsysQual;
   phtp_deglitch uDchg (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .condIn(dischargeOver),
      .holdCycles(degCycles),
      .condOut(dchgQual)
   );
   // Low rail comes from logic on this clock and has a fixed 20 us filter
   phtp_deglitch uVsys (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .condIn(lowSystemVoltage),
      .holdCycles(`PHTP_C20US),
      .condOut(vsysQual)
   );

   // Level triggers gated by their enables
   // Every source has its own enable, so all-clear already means silence;
   // the explicit gate keeps that true should a source ever be added
   wire levelHit = (optTwo_r[`PHTP_EN_COMP] & pinS2_r[2])
      | (optTwo_r[`PHTP_EN_CRIT] & pinS2_r[1])
      | (optTwo_r[`PHTP_EN_NOM] & pinS2_r[0])
      | (optTwo_r[`PHTP_EN_DCHG] & dchgQual)
      | (optTwo_r[`PHTP_EN_SYSTEM_RAIL_VOLTAGE] & vsysQual);
   wire battFall = optTwo_r[`PHTP_EN_BATT] & battPrev_r & !pinS2_r[3];
   wire adptFall = optTwo_r[`PHTP_EN_ADPT] & adptPrev_r & !pinS2_r[4];
   wire trigger = functionOn & (levelHit | battFall | adptFall);
   // A clear is taken straight from the write strobe
   wire clearWrite = regWrite && regAddr == `PHTP_OPT_ZERO_ADDR
      && !regWdata[`PHTP_CLR_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Alert pulse: min width, or held until clear when extended
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         battPrev_r <= 1'b0;
         adptPrev_r <= 1'b0;
         alertActive_r <= 1'b0;
         pending_r <= 1'b0;
         pulseCnt_r <= 24'h000000;
         processorHotAlert_n <= 1'b1;
      end else begin
         // Previous samples reset low, so a pin high at reset shows only a
         // rising edge, which nobody watches; no false removal follows reset
         battPrev_r <= pinS2_r[3];
         adptPrev_r <= pinS2_r[4];
         // A new trigger wins over a release in the same cycle, so a source
         // that is still active keeps the line low even across a clear write
         if (trigger) begin
            alertActive_r <= 1'b1;
            pending_r <= extEnable;
            pulseCnt_r <= 24'h000000;
            processorHotAlert_n <= 1'b0;
         end else if (alertActive_r) begin
            if (pending_r) begin
               if (clearWrite || !extEnable) begin
                  alertActive_r <= 1'b0;
                  pending_r <= 1'b0;
                  processorHotAlert_n <= 1'b1;
               end
            end else if (pulseCnt_r + 24'h000001 >= widCycles) begin
               alertActive_r <= 1'b0;
               processorHotAlert_n <= 1'b1;
            end else begin
               pulseCnt_r <= pulseCnt_r + 24'h000001;
            end
         end
      end
   end
endmodule

// ### logic/phtp_map.vh
`ifndef PHTP_MAP_VH
`define PHTP_MAP_VH
// Register offsets, device-side register address space
`define PHTP_OPT_TWO_ADDR 8'h34
`define PHTP_OPT_ZERO_ADDR 8'h33
`define PHTP_OPT_TWO_RST 16'h8120
`define PHTP_OPT_ZERO_RST 16'h4A54
// Field positions in processor_hot_option_two
`define PHTP_VTH_HI 15
`define PHTP_VTH_LO 10
`define PHTP_DEG_HI 9
`define PHTP_DEG_LO 8
`define PHTP_EN_COMP 6
`define PHTP_EN_CRIT 5
`define PHTP_EN_NOM 4
`define PHTP_EN_DCHG 3
`define PHTP_EN_SYSTEM_RAIL_VOLTAGE 2
`define PHTP_EN_BATT 1
`define PHTP_EN_ADPT 0
// Field positions in option zero (pulse control)
`define PHTP_EXT_BIT 5
`define PHTP_WID_HI 4
`define PHTP_WID_LO 3
`define PHTP_CLR_BIT 2
// Threshold scaling, mA
`define PHTP_STEP_MA 512
`define PHTP_OFFSET_MA 128
// Timing, in ns, and derived cycles at 25 ns
`define PHTP_CLK_NS 25
`define PHTP_T100US_NS 100000
`define PHTP_T1600US_NS 1600000
`define PHTP_T6MS_NS 6000000
`define PHTP_T12MS_NS 12000000
`define PHTP_T1MS_NS 1000000
`define PHTP_T5MS_NS 5000000
`define PHTP_T10MS_NS 10000000
`define PHTP_CYC(t) (((t) + `PHTP_CLK_NS - 1) / `PHTP_CLK_NS)
// Timing counts in clk_sys cycles, sized for the 24-bit counters
`define PHTP_C20US 24'h000320
`define PHTP_C100US 24'h000FA0
`define PHTP_C1MS 24'h009C40
`define PHTP_C1600US 24'h00FA00
`define PHTP_C5MS 24'h030D40
`define PHTP_C6MS 24'h03A980
`define PHTP_C10MS 24'h061A80
`define PHTP_C12MS 24'h075300
`endif

// ### logic/phtp_deglitch.v
`timescale 1ns/1ps
`include "phtp_map.vh"

// Passes a level only after it has stood for the full selected time
module phtp_deglitch (
   input wire clk_sys,
   input wire sys_rst,
   input wire condIn,
   input wire [23:0] holdCycles,
   output reg condOut
);
   reg [23:0] count_r;

   // Any drop restarts the timing
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         count_r <= 24'h000000;
         condOut <= 1'b0;
      end else if (!condIn) begin
         count_r <= 24'h000000;
         condOut <= 1'b0;
      end else if (count_r + 24'h000001 >= holdCycles) begin
         condOut <= 1'b1;
      end else begin
         count_r <= count_r + 24'h000001;
      end
   end
endmodule

// ### bench/phtp_trigger_asserts.sv
`timescale 1ns/1ps
`include "phtp_map.vh"
module phtp_trigger_asserts (
   input wire clk_sys,
   input wire sys_rst,
   input wire regWrite,
   input wire regRead,
   input wire [7:0] regAddr,
   input wire [15:0] regWdata,
   input wire [15:0] regRdata,
   input wire comparatorTrip,
   input wire batteryPresentSignal,
   input wire adapterPresent,
   input wire processorHotAlert_n
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   reg [15:0] optMir_r;
   reg [15:0] lowCnt_r;
   reg extMir_r;
   ////////////////////////////////////////////////////////////////
   // Shadow of option two, follows host writes only
   always @(posedge clk_sys) begin
      if (sys_rst) optMir_r <= `PHTP_OPT_TWO_RST;
      else if (regWrite && regAddr == `PHTP_OPT_TWO_ADDR) optMir_r <= regWdata;
   end
   // Low-time counter, saturates so long holds never wrap
   always @(posedge clk_sys) begin
      if (sys_rst || processorHotAlert_n) lowCnt_r <= 16'h0000;
      else if (lowCnt_r != 16'hFFFF) lowCnt_r <= lowCnt_r + 16'h0001;
   end
   // Extension bit shadow; a clear only releases while extension is on
   always @(posedge clk_sys) begin
      if (sys_rst) extMir_r <= 1'b0;
      else if (regWrite && regAddr == `PHTP_OPT_ZERO_ADDR) extMir_r <= regWdata[`PHTP_EXT_BIT];
   end
   ////////////////////////////////////////////////////////////////
   chk_read_mirror:
   assert property (regRead && regAddr == 8'h34 |=> regRdata == $past(optMir_r))
      else $error("option two readback wrong");
   chk_disabled_quiet:
   assert property (optMir_r[6:0] == 7'h00 && processorHotAlert_n |=> processorHotAlert_n)
      else $error("alert with all sources off");
   chk_fall_enabled:
   assert property ($fell(processorHotAlert_n) |-> $past(optMir_r[6:0]) != 7'h00)
      else $error("alert fell with no enable");
   chk_comp_trigger:
   assert property (optMir_r[6] && $rose(comparatorTrip) |-> ##[1:6] !processorHotAlert_n)
      else $error("comparator did not alert");
   chk_batt_edge:
   assert property (optMir_r[1] && $fell(batteryPresentSignal) |-> ##[1:6] !processorHotAlert_n)
      else $error("battery removal did not alert");
   chk_adapter_edge:
   assert property (optMir_r[0] && $fell(adapterPresent) |-> ##[1:6] !processorHotAlert_n)
      else $error("adapter removal did not alert");
   chk_pulse_width:
   assert property ($rose(processorHotAlert_n) && !$past(regWrite) && !$past(regWrite, 2)
      && !$past(regWrite, 3) |-> lowCnt_r >= 16'h0FA0)
      else $error("alert pulse too short");
   chk_ext_release:
   assert property (extMir_r && regWrite && regAddr == 8'h33 && !regWdata[2]
      |-> ##[1:3] processorHotAlert_n)
      else $error("clear write did not release");
endmodule
bind phtp_trigger phtp_trigger_asserts chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
   .regRdata(regRdata), .comparatorTrip(comparatorTrip),
   .batteryPresentSignal(batteryPresentSignal), .adapterPresent(adapterPresent),
   .processorHotAlert_n(processorHotAlert_n));

// ### bench/phtp_cpu_model.sv
`timescale 1ns/1ps
// Processor side: times each alert pulse it receives
module phtp_cpu_model (
   input wire clk_sys,
   input wire processorHotAlert_n,
   output reg [23:0] lowWidth_r
);
   reg [23:0] run_r = 24'h000000;
   // Latch the low time when the line goes back high
   always @(posedge clk_sys) begin
      if (!processorHotAlert_n) run_r <= run_r + 24'h000001;
      else if (run_r != 24'h000000) begin
         lowWidth_r <= run_r;
         run_r <= 24'h000000;
      end
   end
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   reg clk_sys, sys_rst, regWrite, regRead, batP, adpP;
   reg [7:0] regAddr;
   reg [15:0] regWdata, dcMa;
   reg [3:0] src;
   wire [15:0] regRdata;
   wire alert_n;
   wire [23:0] lowW;
   integer n_mismatch, comparisons, i, k;
   phtp_trigger uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .regWrite(regWrite),
      .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .dischargeCurrentMa(dcMa), .comparatorTrip(src[3]), .criticalInputCurrent(src[2]),
      .nominalInputCurrent(src[1]), .lowSystemVoltage(src[0]),
      .batteryPresentSignal(batP), .adapterPresent(adpP), .processorHotAlert_n(alert_n));
   phtp_cpu_model cpu (.clk_sys(clk_sys), .processorHotAlert_n(alert_n), .lowWidth_r(lowW));
   ////////////////////////////////////////////////////////////////
   // Inputs always move 1 ns after the edge
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk_sys);
         #1;
      end
   endtask
   task cmp16(input [63:0] nm, input [15:0] e, input [15:0] g);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task conclude;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
         if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task wr(input [7:0] a, input [15:0] d);
      begin
         regAddr = a;
         regWdata = d;
         regWrite = 1'b1;
         tick(1);
         regWrite = 1'b0;
         tick(1);
      end
   endtask
   task rd(input [7:0] a, input [15:0] e);
      begin
         regAddr = a;
         regRead = 1'b1;
         tick(1);
         regRead = 0;
         tick(1);
         cmp16("rdata", e, regRdata);
      end
   endtask
   // Bounded wait; running out of time ends the run
   task waitAlert(input v, input integer max);
      begin
         for (i = 0; i < max && alert_n !== v; i = i + 1) tick(1);
         cmp16("alert", {15'h0000, v}, {15'h0000, alert_n});
         if (alert_n !== v) conclude;
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   initial begin
      {regWrite, regRead, regAddr, regWdata, dcMa, src} = 0;
      sys_rst = 1;
      {batP, adpP} = 2'b11;
      n_mismatch = 0;
      comparisons = 0;
      tick(4);
      sys_rst = 0;
      rd(8'h34, 16'h8120);
      rd(8'h20, 16'h0000);
      wr(8'h33, 16'h4A44);
      // One level source at a time, shortest width
      for (k = 0; k < 4; k = k + 1) begin
         wr(8'h34, 16'h8100 | (k < 3 ? 16'h0040 >> k : 16'h0004));
         src = 4'h8 >> k;
         waitAlert(0, 900);
         src = 0;
         waitAlert(1, 4200);
         tick(1);
         cmp16("width", 16'h0001, {15'h0000, lowW >= 24'h000FA0});
      end
      wr(8'h34, 16'h8100);
      {src, batP, adpP} = 6'h3C;
      tick(100);
      cmp16("off", 16'h0001, {15'h0000, alert_n});
      {src, batP, adpP} = 6'h03;
      wr(8'h34, 16'h8102);
      batP = 0;
      waitAlert(0, 10);
      waitAlert(1, 4200);
      tick(100);
      cmp16("oneshot", 16'h0001, {15'h0000, alert_n});
      wr(8'h34, 16'h8101);
      adpP = 0;
      waitAlert(0, 10);
      adpP = 1;
      waitAlert(1, 4200);
      wr(8'h34, 16'h0508);
      dcMa = 16'h0280;
      tick(4100);
      cmp16("equal", 16'h0001, {15'h0000, alert_n});
      dcMa = 16'h0281;
      tick(2000);
      dcMa = 16'h0000;
      tick(3000);
      cmp16("glitch", 16'h0001, {15'h0000, alert_n});
      dcMa = 16'h0281;
      waitAlert(0, 4100);
      dcMa = 16'h0000;
      waitAlert(1, 4200);
      wr(8'h33, 16'h4A64);
      wr(8'h34, 16'h8140);
      src = 4'h8;
      waitAlert(0, 10);
      src = 0;
      tick(4100);
      cmp16("held", 16'h0000, {15'h0000, alert_n});
      wr(8'h33, 16'h4A60);
      waitAlert(1, 3);
      rd(8'h33, 16'h4A64);
      conclude;
   end
endmodule
